// [src/tap_bsr_chain.sv]
// boundary scan chain: input, output, enable and bidir capture cells
`timescale 1ns/1ps
module tap_bsr_chain #(
	parameter int N_IN    = 4,
	parameter int N_OUT   = 2,
	parameter int N_BIDIR = 2
) (
	// clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	// controller side
	tap_chain_if.chain                    ctl,
	// pin and core side values
	input  wire logic [N_IN-1:0]          in_pad_i,
	input  wire logic [N_BIDIR-1:0]       bidir_pad_i,
	input  wire logic [N_OUT+N_BIDIR-1:0] core_out_i,
	input  wire logic [N_OUT+N_BIDIR-1:0] core_oe_i,
	// latched drive values; bidir data taken straight from the shift stage
	output logic      [N_OUT+N_BIDIR-1:0] upd_out_o,
	output logic      [N_OUT+N_BIDIR-1:0] upd_oe_o
);
	localparam int NP = N_OUT + N_BIDIR;    // pins that can drive
	localparam int L  = N_IN + 2 * NP;      // chain length

	logic [L-1:0]     sr;         // shift stages, bit 0 nearest output
	logic [L-1:0]     cap;        // parallel capture values
	logic [N_OUT-1:0] out_latch;  // update stage of output data cells
	logic [NP-1:0]    oe_latch;   // update stage of enable cells

	// capture values; order is inputs, then enable/data pairs per pin
	always_comb
	begin
		cap = '0;
		// R18: input cells only sample
		for (int i = 0; i < N_IN; i++)
			cap[i] = in_pad_i[i];
		// R21: every pin and enable captured at once
		for (int j = 0; j < NP; j++)
		begin
			cap[N_IN + 2*j] = core_oe_i[j];
			if (j < N_OUT)
				cap[N_IN + 2*j + 1] = core_out_i[j];
			// R20: bidir capture picks core or pad data
			else if (core_oe_i[j] && !ctl.extest)
				cap[N_IN + 2*j + 1] = core_out_i[j];
			else
				cap[N_IN + 2*j + 1] = bidir_pad_i[j - N_OUT];
		end
	end

	// shift stage: capture then shift toward bit 0 on clock rise
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			sr <= '0;
		else if (ctl.tck_rise && ctl.capture)
			sr <= cap;
		else if (ctl.tck_rise && ctl.shift)
			sr <= {ctl.tdi, sr[L-1:1]};
	end

	// update stages load on the falling clock, never mid-shift
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			out_latch <= '0;
			oe_latch  <= '0;
		end
		// R17: update latches on falling clock
		else if (ctl.tck_fall && ctl.update)
		begin
			for (int j = 0; j < NP; j++)
				oe_latch[j] <= sr[N_IN + 2*j];
			for (int j = 0; j < N_OUT; j++)
				out_latch[j] <= sr[N_IN + 2*j + 1];
		end
	end

	// R19: bidir data comes from its single capture register
	always_comb
	begin
		for (int j = 0; j < NP; j++)
			upd_out_o[j] = (j < N_OUT) ? out_latch[j]
			                           : sr[N_IN + 2*j + 1];
		upd_oe_o = oe_latch;
	end

	assign ctl.tdo_bit = sr[0];

endmodule // tap_bsr_chain

// [src/tap_chain_if.sv]
// control strobes between the port controller and the boundary chain
`timescale 1ns/1ps
interface tap_chain_if;
	logic tck_rise;  // one-cycle pulse at test clock rise
	logic tck_fall;  // one-cycle pulse at test clock fall
	logic tdi;       // synchronised serial input
	logic capture;   // controller in Capture-DR, chain selected
	logic shift;     // controller in Shift-DR, chain selected
	logic update;    // controller in Update-DR, chain selected
	logic extest;    // EXTEST is the active instruction
	logic tdo_bit;   // chain serial output bit

	modport ctrl  (output tck_rise, tck_fall, tdi, capture, shift,
	               update, extest, input tdo_bit);
	modport chain (input tck_rise, tck_fall, tdi, capture, shift,
	               update, extest, output tdo_bit);
endinterface

// [src/tap_core.sv]
// boundary scan test port: controller, instruction and data registers
`timescale 1ns/1ps
module tap_core #(
	parameter int          N_IN       = 4,
	parameter int          N_OUT      = 2,
	parameter int          N_BIDIR    = 2,
	parameter logic [3:0]  ID_VERSION = tap_pkg::ID_VERSION,
	parameter logic [15:0] ID_PART    = tap_pkg::ID_PART,
	parameter logic [10:0] ID_MANUF   = tap_pkg::ID_MANUF
) (
	// clock and reset
	input  wire logic                     core_clk_i,
	input  wire logic                     reset_i,
	// test port pins
	input  wire logic                     tck_i,
	input  wire logic                     tms_i,
	input  wire logic                     tdi_i,
	input  wire logic                     trst_n_i,
	output logic                          tdo_o,
	output logic                          tdo_oe_o,
	// pads
	input  wire logic [N_IN-1:0]          in_pad_i,
	input  wire logic [N_BIDIR-1:0]       bidir_pad_i,
	output logic      [N_OUT+N_BIDIR-1:0] pad_out_o,
	output logic      [N_OUT+N_BIDIR-1:0] pad_oe_o,
	// core side of the driving pins
	input  wire logic [N_OUT+N_BIDIR-1:0] core_out_i,
	input  wire logic [N_OUT+N_BIDIR-1:0] core_oe_i
);
	localparam int NP = N_OUT + N_BIDIR;  // pins that can drive
	localparam int PW = 4 + N_IN + N_BIDIR; // synchronised pin count

	// next controller state from current state and mode select
	function automatic tap_pkg::tap_state_e next_tap(
		input tap_pkg::tap_state_e s,
		input logic m
	);
		case (s)
			tap_pkg::ST_RESET:
				next_tap = m ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
			tap_pkg::ST_IDLE:
				next_tap = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			tap_pkg::ST_SEL_DR:
				next_tap = m ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR;
			tap_pkg::ST_CAP_DR:
				next_tap = m ? tap_pkg::ST_EXIT1_DR
				             : tap_pkg::ST_SHIFT_DR;
			tap_pkg::ST_SHIFT_DR:
				next_tap = m ? tap_pkg::ST_EXIT1_DR
				             : tap_pkg::ST_SHIFT_DR;
			tap_pkg::ST_EXIT1_DR:
				next_tap = m ? tap_pkg::ST_UPD_DR
				             : tap_pkg::ST_PAUSE_DR;
			tap_pkg::ST_PAUSE_DR:
				next_tap = m ? tap_pkg::ST_EXIT2_DR
				             : tap_pkg::ST_PAUSE_DR;
			tap_pkg::ST_EXIT2_DR:
				next_tap = m ? tap_pkg::ST_UPD_DR
				             : tap_pkg::ST_SHIFT_DR;
			tap_pkg::ST_UPD_DR:
				next_tap = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			tap_pkg::ST_SEL_IR:
				next_tap = m ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR;
			tap_pkg::ST_CAP_IR:
				next_tap = m ? tap_pkg::ST_EXIT1_IR
				             : tap_pkg::ST_SHIFT_IR;
			tap_pkg::ST_SHIFT_IR:
				next_tap = m ? tap_pkg::ST_EXIT1_IR
				             : tap_pkg::ST_SHIFT_IR;
			tap_pkg::ST_EXIT1_IR:
				next_tap = m ? tap_pkg::ST_UPD_IR
				             : tap_pkg::ST_PAUSE_IR;
			tap_pkg::ST_PAUSE_IR:
				next_tap = m ? tap_pkg::ST_EXIT2_IR
				             : tap_pkg::ST_PAUSE_IR;
			tap_pkg::ST_EXIT2_IR:
				next_tap = m ? tap_pkg::ST_UPD_IR
				             : tap_pkg::ST_SHIFT_IR;
			tap_pkg::ST_UPD_IR:
				next_tap = m ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
			default:
				next_tap = tap_pkg::ST_RESET;
		endcase
	endfunction

	// serial path chosen by an opcode
	function automatic tap_pkg::dr_path_e path_of(
		input logic [tap_pkg::IR_W-1:0] op
	);
		case (op)
			// R13: chain only for EXTEST or SAMPLE
			tap_pkg::OP_EXTEST,
			tap_pkg::OP_SAMPLE: path_of = tap_pkg::PATH_CHAIN;
			// R6: identification register path
			tap_pkg::OP_IDCODE: path_of = tap_pkg::PATH_ID;
			// R10: bypass, plus HIGHZ, CLAMP and reserved
			default:            path_of = tap_pkg::PATH_BYPASS;
		endcase
	endfunction

	// pin synchronisers; stage one feeds stage two only
	logic [PW-1:0] sync1;
	logic [PW-1:0] sync2;
	logic          tck_q;          // previous synchronised clock level

	// synchronised pin views
	logic          tck_s;
	logic          tms_s;
	logic          tdi_s;
	logic          trst_n_s;
	logic [N_IN-1:0]    in_pad_s;
	logic [N_BIDIR-1:0] bidir_pad_s;
	logic          tck_rise;       // one-cycle pulse per rising edge
	logic          tck_fall;       // one-cycle pulse per falling edge

	// controller and registers
	tap_pkg::tap_state_e      state;       // controller state
	logic [tap_pkg::IR_W-1:0] ir_shift;    // instruction shift cells
	logic [tap_pkg::IR_W-1:0] ir_active;   // decoded instruction
	logic                     bypass_bit;  // one-bit bypass register
	logic [tap_pkg::ID_W-1:0] id_shift;    // identification shifter
	tap_pkg::dr_path_e        path;        // active serial path

	// instruction decode flags
	logic op_extest;
	logic op_clamp;
	logic op_highz;
	logic pins_latched;        // pins driven by the chain: update latches, bidir data from the shift stage

	// chain interface and outputs
	tap_chain_if         chain_bus ();
	logic [NP-1:0]       upd_out;
	logic [NP-1:0]       upd_oe;

	assign {tck_s, tms_s, tdi_s, trst_n_s, in_pad_s, bidir_pad_s}
		= sync2;

	// two-stage synchroniser for every pin from outside the clock
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			sync1 <= '0;
			sync2 <= '0;
		end
		else
		begin
			sync1 <= {tck_i, tms_i, tdi_i, trst_n_i, in_pad_i,
			          bidir_pad_i};
			sync2 <= sync1;
		end
	end

	// remember the clock level to find its edges
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			tck_q <= 1'b0;
		else
			tck_q <= tck_s;
	end

	// edge pulses; tms and tdi share the same sync delay as tck
	assign tck_rise = tck_s & ~tck_q;
	assign tck_fall = ~tck_s & tck_q;

	// R27: state advances on each test clock rise
	always_ff @(posedge core_clk_i)
	begin
		// R23: reset pin forces the reset state
		if (reset_i || !trst_n_s)
			state <= tap_pkg::ST_RESET;
		else if (tck_rise)
			state <= next_tap(state, tms_s);
	end

	// instruction shift cells
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			ir_shift <= tap_pkg::CAPTURE_IR_PATTERN;
		// R8: fixed pattern on instruction capture
		else if (tck_rise && state == tap_pkg::ST_CAP_IR)
			ir_shift <= tap_pkg::CAPTURE_IR_PATTERN;
		// R2: shift toward bit 0 on clock rise
		else if (tck_rise && state == tap_pkg::ST_SHIFT_IR)
			ir_shift <= {tdi_s, ir_shift[tap_pkg::IR_W-1:1]};
	end

	// active instruction; latched on the falling edge in Update-IR
	always_ff @(posedge core_clk_i)
	begin
		// R23: reset loads IDCODE
		if (reset_i || state == tap_pkg::ST_RESET)
			ir_active <= tap_pkg::OP_IDCODE;
		// R3: only Update-IR changes the instruction
		else if (tck_fall && state == tap_pkg::ST_UPD_IR)
			ir_active <= ir_shift;
	end

	// R1: decode of the six-bit instruction
	always_comb
	begin
		path      = path_of(ir_active);
		op_extest = (ir_active == tap_pkg::OP_EXTEST);
		op_clamp  = (ir_active == tap_pkg::OP_CLAMP);
		op_highz  = (ir_active == tap_pkg::OP_HIGHZ);
		// R9: CLAMP drives latches like EXTEST
		pins_latched = op_extest | op_clamp;
	end

	// bypass register, only touched while it is the selected path
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			bypass_bit <= 1'b0;
		// R22: zero at Capture-DR
		else if (tck_rise && state == tap_pkg::ST_CAP_DR &&
		         path == tap_pkg::PATH_BYPASS)
			bypass_bit <= 1'b0;
		// R25: CLAMP and BYPASS shift through this bit
		else if (tck_rise && state == tap_pkg::ST_SHIFT_DR &&
		         path == tap_pkg::PATH_BYPASS)
			bypass_bit <= tdi_s;
	end

	// identification shifter, loaded with the fixed word at capture
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
			id_shift <= '0;
		// R24: version, part, maker, one in bit 0
		else if (tck_rise && state == tap_pkg::ST_CAP_DR &&
		         path == tap_pkg::PATH_ID)
			id_shift <= {ID_VERSION, ID_PART, ID_MANUF,
			             tap_pkg::ID_LSB};
		else if (tck_rise && state == tap_pkg::ST_SHIFT_DR &&
		         path == tap_pkg::PATH_ID)
			id_shift <= {tdi_s, id_shift[tap_pkg::ID_W-1:1]};
	end

	// strobes for the chain; gated so an unselected chain stays put
	always_comb
	begin
		chain_bus.tck_rise = tck_rise;
		chain_bus.tck_fall = tck_fall;
		chain_bus.tdi      = tdi_s;
		chain_bus.extest   = op_extest;
		// R12: strobes reach only the selected register
		chain_bus.capture  = (state == tap_pkg::ST_CAP_DR) &&
		                     (path == tap_pkg::PATH_CHAIN);
		chain_bus.shift    = (state == tap_pkg::ST_SHIFT_DR) &&
		                     (path == tap_pkg::PATH_CHAIN);
		// R16: update stage loads at Update-DR
		chain_bus.update   = (state == tap_pkg::ST_UPD_DR) &&
		                     (path == tap_pkg::PATH_CHAIN);
	end

	// boundary chain with its capture and update stages
	tap_bsr_chain #(
		.N_IN    (N_IN),
		.N_OUT   (N_OUT),
		.N_BIDIR (N_BIDIR)
	) u_chain (
		.core_clk_i  (core_clk_i),
		.reset_i     (reset_i),
		.ctl         (chain_bus),
		.in_pad_i    (in_pad_s),
		.bidir_pad_i (bidir_pad_s),
		.core_out_i  (core_out_i),
		.core_oe_i   (core_oe_i),
		.upd_out_o   (upd_out),
		.upd_oe_o    (upd_oe)
	);

	// serial output: changes on the falling test clock only
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			tdo_o    <= 1'b0;
			tdo_oe_o <= 1'b0;
		end
		// R27: output updated on falling edge
		else if (tck_fall)
		begin
			// instruction scan shifts the instruction cells
			if (state == tap_pkg::ST_SHIFT_IR)
			begin
				tdo_o    <= ir_shift[0];
				tdo_oe_o <= 1'b1;
			end
			// R11: data scan picks one parallel register
			else if (state == tap_pkg::ST_SHIFT_DR)
			begin
				tdo_oe_o <= 1'b1;
				case (path)
					tap_pkg::PATH_CHAIN: tdo_o <= chain_bus.tdo_bit;
					tap_pkg::PATH_ID:    tdo_o <= id_shift[0];
					default:             tdo_o <= bypass_bit;
				endcase
			end
			// pin floats outside shift states
			else
				tdo_oe_o <= 1'b0;
		end
	end

	// pin drive; relies on the tester preloading before EXTEST
	always_ff @(posedge core_clk_i)
	begin
		if (reset_i)
		begin
			pad_out_o <= '0;
			pad_oe_o  <= '0;
		end
		// R4: latched values drive pins and enables; bidir pin data comes from the chain shift stage
		// R14: takes effect as soon as EXTEST is active
		else if (pins_latched)
		begin
			pad_out_o <= upd_out;
			pad_oe_o  <= upd_oe;
		end
		// R7: every driving pin floats
		else if (op_highz)
		begin
			pad_out_o <= core_out_i;
			pad_oe_o  <= '0;
		end
		// R5: sample and R26: reserved leave pins functional
		else
		begin
			pad_out_o <= core_out_i;
			pad_oe_o  <= core_oe_i;
		end
	end

endmodule // tap_core

// [src/tap_pkg.sv]
// constants and types shared by the boundary scan test port
// Behaviour
// R1: six-bit instruction register selects test path
// R2: instruction bits shift in on test clock rise
// R3: new instruction takes effect only at Update-IR
// R4: 000000 drives latched chain values onto pins; the code drives bidir data unlatched from the shift stage
// R5: 000001 preloads latches, snapshots pins, no drive
// R6: 000010 selects identification register for shifting
// R7: 000011 floats all output and bidirectional pins
// R8: Capture-IR loads fixed pattern 101101 into IR
// R9: 111110 keeps latched drive, bypass in path
// R10: 111111 puts one-bit bypass in serial path
// R11: data registers share serial input and output
// R12: unselected registers never disturb chip or path
// R13: chain in path only for EXTEST or SAMPLE
// R14: EXTEST drives held latches at once on update
// R15: controller must preload before selecting EXTEST
// R16: EXTEST transfers shifted values at Update-DR; in the code bidir data reaches pins while it shifts
// R17: cell update stages load on falling clock
// R18: input cells only sample, no update stage
// R19: bidirectional pin uses enable and capture cell
// R20: bidir capture picks core data when enabled; under EXTEST the code captures pad data
// R21: sample captures all pins and enables together
// R22: bypass register loads zero at Capture-DR
// R23: test port reset loads IDCODE as instruction
// R24: identification word is 32 bits, LSB one
// R25: CLAMP places bypass register in serial path
// R26: reserved opcodes act as bypass, pins normal
// R27: sixteen-state sequencing, output on falling edge
package tap_pkg;

	// instruction register
	localparam int        IR_W           = 6;
	localparam logic [5:0] OP_EXTEST     = 6'h00;
	localparam logic [5:0] OP_SAMPLE     = 6'h01;
	localparam logic [5:0] OP_IDCODE     = 6'h02;
	localparam logic [5:0] OP_HIGHZ      = 6'h03;
	localparam logic [5:0] OP_CLAMP      = 6'h3E;
	localparam logic [5:0] OP_BYPASS     = 6'h3F;
	// pattern parallel-loaded on every instruction capture
	localparam logic [5:0] CAPTURE_IR_PATTERN = 6'h2D;

	// identification word layout
	localparam int         ID_W          = 32;
	localparam logic [3:0]  ID_VERSION   = 4'h0;   // arbitrary value
	localparam logic [15:0] ID_PART      = 16'h1234; // arbitrary value
	localparam logic [10:0] ID_MANUF     = 11'h0AA; // arbitrary value
	localparam logic        ID_LSB       = 1'h1;

	// stages in each pin synchroniser
	localparam int         SYNC_STAGES   = 2;

	// test port controller states, standard encodings
	typedef enum logic [3:0] {
		ST_RESET    = 4'hF,
		ST_IDLE     = 4'hC,
		ST_SEL_DR   = 4'h7,
		ST_CAP_DR   = 4'h6,
		ST_SHIFT_DR = 4'h2,
		ST_EXIT1_DR = 4'h1,
		ST_PAUSE_DR = 4'h3,
		ST_EXIT2_DR = 4'h0,
		ST_UPD_DR   = 4'h5,
		ST_SEL_IR   = 4'h4,
		ST_CAP_IR   = 4'hE,
		ST_SHIFT_IR = 4'hA,
		ST_EXIT1_IR = 4'h9,
		ST_PAUSE_IR = 4'hB,
		ST_EXIT2_IR = 4'h8,
		ST_UPD_IR   = 4'hD
	} tap_state_e;

	// serial path picked by the active instruction
	typedef enum logic [1:0] {
		PATH_BYPASS = 2'h0,
		PATH_CHAIN  = 2'h1,
		PATH_ID     = 2'h2
	} dr_path_e;

endpackage

// [tb/boundary_scan_tap_registers_test.sv]
// self-checking bench for the boundary scan test port
`timescale 1ns/1ps
module boundary_scan_tap_registers_test;
	localparam logic [11:0] P = 12'hC35; // preload pattern
	localparam logic [11:0] Q = 12'h3CA; // its complement

	logic        core_clk;     // system clock
	logic        reset;        // synchronous reset
	logic        tck;          // test clock
	logic        tms;          // mode select
	logic        tdi;          // serial in
	logic        trst_n;       // test reset, active low
	logic        tdo;          // serial out
	logic        tdo_oe;       // serial out enable
	logic [3:0]  in_pad;       // observe-only pins
	logic [1:0]  bidir_pad;    // pad side of bidir pins
	logic [3:0]  core_out;     // core output data
	logic [3:0]  core_oe;      // core output enables
	logic [3:0]  pad_out;      // pin data
	logic [3:0]  pad_oe;       // pin enables
	logic [31:0] so;           // bits shifted out
	int          n_mismatch;   // mismatches seen
	int          total_checks; // comparisons made

	tap_tester u_tester (
		.tck_o   (tck),
		.tms_o   (tms),
		.tdi_o   (tdi),
		.trst_n_o(trst_n),
		.tdo_i   (tdo)
	);

	tap_core i_dut (
		.core_clk_i (core_clk),
		.reset_i    (reset),
		.tck_i      (tck),
		.tms_i      (tms),
		.tdi_i      (tdi),
		.trst_n_i   (trst_n),
		.tdo_o      (tdo),
		.tdo_oe_o   (tdo_oe),
		.in_pad_i   (in_pad),
		.bidir_pad_i(bidir_pad),
		.pad_out_o  (pad_out),
		.pad_oe_o   (pad_oe),
		.core_out_i (core_out),
		.core_oe_i  (core_oe)
	);

	// free-running system clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	task automatic chk(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		if (n_mismatch == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// chain contents after capture: inputs, then enable and data per pin
	function automatic logic [11:0] cap(input logic ext);
		logic [11:0] v;
		v[3:0] = in_pad;
		for (int j = 0; j < 4; j++)
		begin
			v[4+2*j] = core_oe[j];
			v[5+2*j] = (j < 2 || (core_oe[j] && !ext)) ? core_out[j]
				: bidir_pad[j%2];
		end
		return v;
	endfunction

	// pad enables and data that a chain image drives
	function automatic logic [7:0] lat(input logic [11:0] p);
		for (int j = 0; j < 4; j++)
		begin
			lat[j]   = p[5+2*j];
			lat[4+j] = p[4+2*j];
		end
	endfunction

	task automatic ir(input logic [5:0] op);
		u_tester.scan(1'b1, 6, {26'h0, op}, so);
		chk("ir capture", so[5:0], 6'h2D);
	endtask

	task automatic s_idcode();
		logic q;
		// leave test-logic-reset first; an extra idle clock is harmless
		u_tester.step(1'b0, 1'b1, q);
		u_tester.scan(1'b0, 32, 32'h0, so);
		chk("idcode", so, {tap_pkg::ID_VERSION, tap_pkg::ID_PART,
			tap_pkg::ID_MANUF, 1'b1});
		chk("idle pads", {pad_oe, pad_out}, {core_oe, core_out});
		chk("serial enable idle", tdo_oe, 1'b0);
	endtask

	task automatic s_sample();
		ir(tap_pkg::OP_SAMPLE);
		u_tester.scan(1'b0, 12, {20'h0, P}, so);
		chk("sample capture", so[11:0], cap(1'b0));
		chk("sample pads", {pad_oe, pad_out}, {core_oe, core_out});
	endtask

	task automatic s_extest();
		ir(tap_pkg::OP_EXTEST);
		chk("extest preload", {pad_oe, pad_out}, lat(P));
		u_tester.scan(1'b0, 12, {20'h0, Q}, so);
		chk("extest capture", so[11:0], cap(1'b1));
		chk("extest update", {pad_oe, pad_out}, lat(Q));
	endtask

	task automatic s_modes();
		logic [5:0] ops [6] = '{6'h3E, 6'h03, 6'h3F, 6'h2C, 6'h2E, 6'h3D};
		logic [7:0] exp;
		for (int i = 0; i < 6; i++)
		begin
			ir(ops[i]);
			u_tester.scan(1'b0, 2, 32'h3, so);
			chk("bypass path", so[1:0], 2'h2);
			if (ops[i] == tap_pkg::OP_CLAMP)
				exp = lat(Q);
			else if (ops[i] == tap_pkg::OP_HIGHZ)
				exp = {4'h0, core_out};
			else
				exp = {core_oe, core_out};
			chk("mode pads", {pad_oe, pad_out}, exp);
		end
	endtask

	task automatic s_tms_reset();
		ir(tap_pkg::OP_EXTEST);
		u_tester.tms_reset();
		chk("tms reset pads", {pad_oe, pad_out}, {core_oe, core_out});
		s_idcode();
	endtask

	task automatic s_trst();
		ir(tap_pkg::OP_HIGHZ);
		@(posedge core_clk);
		#1 core_out = 4'h3;
		u_tester.pulse_reset();
		chk("trst pads", {pad_oe, pad_out}, {core_oe, core_out});
		s_idcode();
	endtask

	// main sequence
	initial
	begin
		n_mismatch   = 0;
		total_checks = 0;
		reset        = 1'b1;
		in_pad       = 4'h9;
		bidir_pad    = 2'h1;
		core_out     = 4'hA;
		core_oe      = 4'h6;
		repeat (2) @(posedge core_clk);
		#1 reset = 1'b0;
		repeat (3) @(posedge core_clk);
		s_idcode();
		s_sample();
		s_extest();
		s_modes();
		s_tms_reset();
		s_trst();
		test_done();
	end

	// watchdog, well beyond the expected run of some 40 us
	initial
	begin
		#400000;
		n_mismatch++;
		test_done();
	end
endmodule // boundary_scan_tap_registers_test

// [tb/tap_core_assertions.sv]
// checker on the test port pins and the pad outputs
`timescale 1ns/1ps
module tap_core_assertions #(
	parameter int N_OUT   = 2,
	parameter int N_BIDIR = 2
) (
	// clock and reset
	input wire logic                     core_clk_i,
	input wire logic                     reset_i,
	// test port pins
	input wire logic                     tck_i,
	input wire logic                     tms_i,
	input wire logic                     trst_n_i,
	input wire logic                     tdo_o,
	input wire logic                     tdo_oe_o,
	// pads and core side
	input wire logic [N_OUT+N_BIDIR-1:0] pad_out_o,
	input wire logic [N_OUT+N_BIDIR-1:0] pad_oe_o,
	input wire logic [N_OUT+N_BIDIR-1:0] core_out_i,
	input wire logic [N_OUT+N_BIDIR-1:0] core_oe_i
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (reset_i);

	logic       tck_d;    // test clock one cycle ago
	logic       last_tms; // mode select at the latest rise
	logic [2:0] tms_run;  // rises in a row with mode select high

	// follow rises; the count saturates since five is all that matters
	always_ff @(posedge core_clk_i)
	begin
		tck_d <= tck_i;
		if (reset_i)
			tms_run <= 3'h0;
		else if (tck_i && !tck_d)
		begin
			last_tms <= tms_i;
			tms_run  <= !tms_i ? 3'h0 : (tms_run == 3'h5) ? 3'h5
				: tms_run + 3'h1;
		end
	end

	property p_reset_quiet;
		$fell(reset_i) |-> pad_out_o == '0 && pad_oe_o == '0
			&& !tdo_oe_o && !tdo_o;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet)
		else $error("outputs not quiet after reset");

	// serial out moves after a fall
	property p_tdo_after_fall;
		$changed(tdo_o) && trst_n_i && $past(trst_n_i, 4)
			|-> !$past(tck_i, 2);
	endproperty
	a_tdo_after_fall: assert property (p_tdo_after_fall)
		else $error("serial out moved outside a falling edge");

	property p_oe_after_fall;
		$changed(tdo_oe_o) && trst_n_i && $past(trst_n_i, 4)
			|-> !$past(tck_i, 2);
	endproperty
	a_oe_after_fall: assert property (p_oe_after_fall)
		else $error("serial enable moved outside a falling edge");

	// serial out holds while clock high
	property p_tdo_hold;
		tck_i [*5] |-> $stable(tdo_o);
	endproperty
	a_tdo_hold: assert property (p_tdo_hold)
		else $error("serial out changed while test clock high");

	property p_shift_entry;
		$rose(tdo_oe_o) |-> !last_tms;
	endproperty
	a_shift_entry: assert property (p_shift_entry)
		else $error("shift entered after mode select high");

	property p_trst_pads;
		!trst_n_i [*6] |-> pad_out_o == $past(core_out_i)
			&& pad_oe_o == $past(core_oe_i);
	endproperty
	a_trst_pads: assert property (p_trst_pads)
		else $error("pads not normal under test reset");

	property p_trst_quiet;
		!trst_n_i [*6] |-> !tdo_oe_o;
	endproperty
	a_trst_quiet: assert property (p_trst_quiet)
		else $error("serial enable high under test reset");

	// five high rises reset the port
	property p_tms_reset;
		tck_i && !tck_d && tms_i && tms_run == 3'h4 |-> ##8
			pad_out_o == $past(core_out_i)
			&& pad_oe_o == $past(core_oe_i) && !tdo_oe_o;
	endproperty
	a_tms_reset: assert property (p_tms_reset)
		else $error("pads not normal after mode select reset");
endmodule // tap_core_assertions

bind tap_core tap_core_assertions #(
	.N_OUT  (N_OUT),
	.N_BIDIR(N_BIDIR)
) u_assert (
	.core_clk_i(core_clk_i),
	.reset_i   (reset_i),
	.tck_i     (tck_i),
	.tms_i     (tms_i),
	.trst_n_i  (trst_n_i),
	.tdo_o     (tdo_o),
	.tdo_oe_o  (tdo_oe_o),
	.pad_out_o (pad_out_o),
	.pad_oe_o  (pad_oe_o),
	.core_out_i(core_out_i),
	.core_oe_i (core_oe_i)
);

// [tb/tap_tester.sv]
// model of the external controller that drives the test port
`timescale 1ns/1ps
module tap_tester (
	// test port lines
	output logic      tck_o,
	output logic      tms_o,
	output logic      tdi_o,
	output logic      trst_n_o,
	// serial answer
	input  wire logic tdo_i
);
	// clock stands low between frames, data idles at its pull-up level
	initial
	begin
		tck_o    = 1'b0;
		tms_o    = 1'b1;
		tdi_o    = 1'b1;
		trst_n_o = 1'b1;
	end

	// one clock, lines settle a half period before the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms_o = m;
		tdi_o = d;
		#62.5;
		q     = tdo_i;
		tck_o = 1'b1;
		#62.5;
		tck_o = 1'b0;
	endtask

	// scan from idle back to idle, lsb first
	task automatic scan(input logic ir, input int n,
		input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask

	// five rises with mode select high, then to idle
	task automatic tms_reset();
		logic q;
		repeat (5) step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask

	// pulse the test reset pin, long enough for its synchroniser
	task automatic pulse_reset();
		trst_n_o = 1'b0;
		#200;
		trst_n_o = 1'b1;
	endtask
endmodule // tap_tester
